/* rtl/lerc_top.v */
// lane mask, ramp check and constant output test register bank with its datapath
//
// Summary of operation
// - eight mask bits enable receive lanes individually
// - ramp verify off accepts any alignment data
// - ramp verify on expects bytes 00,01,02 onward
// - ramp mismatch fails alignment, blocks start-up
// - I constant split into low, high bytes
// - Q constant split into low, high bytes
`timescale 1ns/1ps
`include "lerc_consts.vh"

module lerc_top (
	// clock and reset
	input  wire        clk,
	input  wire        resetn,
	// serial control port register access
	input  wire [12:0] reg_addr,
	input  wire        reg_wr,
	input  wire [7:0]  reg_wdata,
	input  wire        reg_rd,
	output reg  [7:0]  reg_rdata,
	// alignment sequence from the link
	input  wire        ilas_start,
	input  wire        ilas_end,
	input  wire [7:0]  ilas_valid,
	input  wire [63:0] ilas_data,
	// link status
	output wire [7:0]  link_lane_mask_bits,
	output reg  [7:0]  lane_fail,
	output reg         ilas_failed,
	output reg         startup_ok,
	// sample datapath
	input  wire [15:0] i_link_data,
	input  wire [15:0] q_link_data,
	output reg  [15:0] i_dac_data,
	output reg  [15:0] q_dac_data
);

	localparam [1:0] PH_IDLE = 2'b00;
	localparam [1:0] PH_WAIT = 2'b01;
	localparam [1:0] PH_PASS = 2'b10;
	localparam [1:0] PH_FAIL = 2'b11;

	reg  [7:0]  link_lane_mask_reg;
	reg         alignment_ramp_verify_on_reg;
	reg  [7:0]  digital_test_control_reg;
	reg  [7:0]  i_constant_low_byte_reg;
	reg  [7:0]  i_constant_high_byte_reg;
	reg  [7:0]  q_constant_low_byte_reg;
	reg  [7:0]  q_constant_high_byte_reg;
	reg  [7:0]  rdata_next;
	wire [15:0] i_path_constant_value;
	wire [15:0] q_path_constant_value;
	wire        constant_output_test_select;
	wire [7:0]  fail_now;
	wire        any_fail;
	wire        hit_lane_mask;
	wire        hit_ramp_ctrl;
	wire        hit_dig_test;
	wire        hit_i_low;
	wire        hit_i_high;
	wire        hit_q_low;
	wire        hit_q_high;
	reg  [1:0]  phase_reg;
	reg  [1:0]  phase_next;

	assign link_lane_mask_bits         = link_lane_mask_reg;
	assign constant_output_test_select = digital_test_control_reg[`LERC_BIT_CONST_TEST];
	assign i_path_constant_value       = {i_constant_high_byte_reg, i_constant_low_byte_reg};
	assign q_path_constant_value       = {q_constant_high_byte_reg, q_constant_low_byte_reg};

	// address decode shared by the write processes
	assign hit_lane_mask = (reg_addr == `LERC_OFS_LANE_MASK);
	assign hit_ramp_ctrl = (reg_addr == `LERC_OFS_RAMP_CTRL);
	assign hit_dig_test  = (reg_addr == `LERC_OFS_DIG_TEST);
	assign hit_i_low     = (reg_addr == `LERC_OFS_I_LOW);
	assign hit_i_high    = (reg_addr == `LERC_OFS_I_HIGH);
	assign hit_q_low     = (reg_addr == `LERC_OFS_Q_LOW);
	assign hit_q_high    = (reg_addr == `LERC_OFS_Q_HIGH);

	// register writes, one process per register
	always @(posedge clk or negedge resetn) begin
		if (!resetn)
			link_lane_mask_reg <= `LERC_RST_LANE_MASK;
		else if (reg_wr && hit_lane_mask)
			link_lane_mask_reg <= reg_wdata;
	end

	always @(posedge clk or negedge resetn) begin
		if (!resetn)
			alignment_ramp_verify_on_reg <= 1'b0;
		else if (reg_wr && hit_ramp_ctrl)
			alignment_ramp_verify_on_reg <= reg_wdata[`LERC_BIT_RAMP_VERIFY];
	end

	// reserved bits are stored as written; software keeps the default
	always @(posedge clk or negedge resetn) begin
		if (!resetn)
			digital_test_control_reg <= `LERC_RST_DIG_TEST;
		else if (reg_wr && hit_dig_test)
			digital_test_control_reg <= reg_wdata;
	end

	always @(posedge clk or negedge resetn) begin
		if (!resetn)
			i_constant_low_byte_reg <= `LERC_RST_CONST_BYTE;
		else if (reg_wr && hit_i_low)
			i_constant_low_byte_reg <= reg_wdata;
	end

	always @(posedge clk or negedge resetn) begin
		if (!resetn)
			i_constant_high_byte_reg <= `LERC_RST_CONST_BYTE;
		else if (reg_wr && hit_i_high)
			i_constant_high_byte_reg <= reg_wdata;
	end

	always @(posedge clk or negedge resetn) begin
		if (!resetn)
			q_constant_low_byte_reg <= `LERC_RST_CONST_BYTE;
		else if (reg_wr && hit_q_low)
			q_constant_low_byte_reg <= reg_wdata;
	end

	always @(posedge clk or negedge resetn) begin
		if (!resetn)
			q_constant_high_byte_reg <= `LERC_RST_CONST_BYTE;
		else if (reg_wr && hit_q_high)
			q_constant_high_byte_reg <= reg_wdata;
	end

	// read decode; the ramp verify bit is write-only and reads zero
	always @* begin
		rdata_next = 8'h00;
		case (reg_addr)
		`LERC_OFS_LANE_MASK: rdata_next = link_lane_mask_reg;
		`LERC_OFS_RAMP_CTRL: rdata_next = 8'h00;
		`LERC_OFS_DIG_TEST:  rdata_next = digital_test_control_reg;
		`LERC_OFS_I_LOW:     rdata_next = i_constant_low_byte_reg;
		`LERC_OFS_I_HIGH:    rdata_next = i_constant_high_byte_reg;
		`LERC_OFS_Q_LOW:     rdata_next = q_constant_low_byte_reg;
		`LERC_OFS_Q_HIGH:    rdata_next = q_constant_high_byte_reg;
		default:             rdata_next = 8'h00;
		endcase
	end

	always @(posedge clk or negedge resetn) begin
		if (!resetn)
			reg_rdata <= 8'h00;
		else if (reg_rd)
			reg_rdata <= rdata_next;
	end

	// per-lane ramp checkers, active only on enabled lanes
	genvar g;
	generate
		for (g = 0; g < `LERC_LANES; g = g + 1) begin : lane
			lerc_ramp_check u_chk (
				.clk        (clk),
				.resetn     (resetn),
				.check_on   (alignment_ramp_verify_on_reg & link_lane_mask_reg[g]),
				.seq_start  (ilas_start),
				.byte_valid (ilas_valid[g]),
				.byte_data  (ilas_data[g*8 +: 8]),
				.fail_now   (fail_now[g]),
				.fail_reg   ()
			);
		end
	endgenerate

	assign any_fail = |fail_now;

	// alignment phase: an end is judged only inside a started sequence
	always @* begin
		phase_next = phase_reg;
		case (phase_reg)
		PH_IDLE: begin
			if (ilas_start)
				phase_next = PH_WAIT;
		end
		PH_WAIT: begin
			if (ilas_start)
				phase_next = PH_WAIT;
			else if (ilas_end)
				phase_next = any_fail ? PH_FAIL : PH_PASS;
		end
		PH_PASS: begin
			if (ilas_start)
				phase_next = PH_WAIT;
		end
		PH_FAIL: begin
			if (ilas_start)
				phase_next = PH_WAIT;
		end
		default: begin
			phase_next = PH_IDLE;
		end
		endcase
	end

	always @(posedge clk or negedge resetn) begin
		if (!resetn)
			phase_reg <= PH_IDLE;
		else
			phase_reg <= phase_next;
	end

	// outcome flags follow the phase; start-up only after a clean sequence
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			lane_fail   <= 8'h00;
			ilas_failed <= 1'b0;
			startup_ok  <= 1'b0;
		end else begin
			ilas_failed <= (phase_next == PH_FAIL);
			startup_ok  <= (phase_next == PH_PASS);
			if (ilas_start)
				lane_fail <= 8'h00;
			else if (ilas_end && phase_reg == PH_WAIT)
				lane_fail <= fail_now;
		end
	end

	// sample path: constants replace link data in test mode
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			i_dac_data <= 16'h0000;
			q_dac_data <= 16'h0000;
		end else if (constant_output_test_select) begin
			i_dac_data <= i_path_constant_value;
			q_dac_data <= q_path_constant_value;
		end else begin
			i_dac_data <= i_link_data;
			q_dac_data <= q_link_data;
		end
	end

endmodule

/* rtl/lerc_consts.vh */
// register offsets, field positions, reset values and widths of the lane and test bank
`ifndef LERC_CONSTS_VH
`define LERC_CONSTS_VH

`define LERC_ADDR_W            13
`define LERC_LANES             8

`define LERC_OFS_LANE_MASK     13'h047d
`define LERC_OFS_RAMP_CTRL     13'h047e
`define LERC_OFS_DIG_TEST      13'h0520
`define LERC_OFS_I_LOW         13'h0521
`define LERC_OFS_I_HIGH        13'h0522
`define LERC_OFS_Q_LOW         13'h0523
`define LERC_OFS_Q_HIGH        13'h0524

`define LERC_BIT_RAMP_VERIFY   0
`define LERC_BIT_CONST_TEST    1

`define LERC_RST_LANE_MASK     8'h00
`define LERC_RST_RAMP_CTRL     8'h00
`define LERC_RST_DIG_TEST      8'h1c
`define LERC_RST_CONST_BYTE    8'h00

`define LERC_RAMP_FIRST        8'h00
`define LERC_RAMP_STEP         8'h01

`endif

/* rtl/lerc_ramp_check.v */
// one lane's alignment-sequence ramp checker
`timescale 1ns/1ps
`include "lerc_consts.vh"

module lerc_ramp_check (
	// clock and reset
	input  wire       clk,
	input  wire       resetn,
	// control
	input  wire       check_on,
	input  wire       seq_start,
	// received alignment bytes
	input  wire       byte_valid,
	input  wire [7:0] byte_data,
	// result
	output wire       fail_now,
	output reg        fail_reg
);

	reg  [7:0] expect_reg;
	wire       mismatch;

	// a byte counts only when checking is on and it is not the start cycle
	assign mismatch = check_on & byte_valid & ~seq_start & (byte_data != expect_reg);
	assign fail_now = fail_reg | mismatch;

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			expect_reg <= `LERC_RAMP_FIRST;
			fail_reg   <= 1'b0;
		end else if (seq_start) begin
			expect_reg <= `LERC_RAMP_FIRST;
			fail_reg   <= 1'b0;
		end else begin
			if (byte_valid)
				expect_reg <= expect_reg + `LERC_RAMP_STEP;
			if (mismatch)
				fail_reg <= 1'b1;
		end
	end

endmodule

/* verif/lerc_chk.sv */
// assertion checker for the lane and test register bank
`timescale 1ns/1ps
module lerc_chk (
	// clock and reset
	input wire        clk,
	input wire        resetn,
	// watched ports
	input wire [12:0] reg_addr,
	input wire        reg_wr,
	input wire [7:0]  reg_wdata,
	input wire        reg_rd,
	input wire [7:0]  reg_rdata,
	input wire        ilas_end,
	input wire [7:0]  link_lane_mask_bits,
	input wire [7:0]  lane_fail,
	input wire        ilas_failed,
	input wire        startup_ok,
	input wire [15:0] i_link_data,
	input wire [15:0] i_dac_data
);
	reg mode_h, ramp_h;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	// shadow of the test select and ramp verify bits
	always @(posedge clk or negedge resetn)
		if (!resetn) {mode_h, ramp_h} <= 2'h0;
		else if (reg_wr && reg_addr == 13'h0520) mode_h <= reg_wdata[1];
		else if (reg_wr && reg_addr == 13'h047e) ramp_h <= reg_wdata[0];
	property p_mask; reg_wr && reg_addr == 13'h047d |=> link_lane_mask_bits == $past(reg_wdata); endproperty
	a_mask: assert property (p_mask) else $error("lane mask");
	property p_off; ilas_end && !ramp_h |=> startup_ok && !ilas_failed; endproperty
	a_off: assert property (p_off) else $error("check off");
	property p_end; ilas_end |=> startup_ok != ilas_failed && ilas_failed == |lane_fail; endproperty
	a_end: assert property (p_end) else $error("outcome");
	property p_rw; reg_rd && $past(reg_wr) && reg_addr == $past(reg_addr)
		&& reg_addr inside {[13'h0520:13'h0524]} |=> reg_rdata == $past(reg_wdata, 2); endproperty
	a_rw: assert property (p_rw) else $error("readback");
	property p_dc; !mode_h |=> i_dac_data == $past(i_link_data); endproperty
	a_dc: assert property (p_dc) else $error("datapath");
	property p_wo; reg_rd && reg_addr == 13'h047e |=> reg_rdata == 8'h00; endproperty
	a_wo: assert property (p_wo) else $error("write-only read");
	property p_lane; ilas_end |=> (lane_fail & ~link_lane_mask_bits) == 8'h00; endproperty
	a_lane: assert property (p_lane) else $error("masked lane");
endmodule
bind lerc_top lerc_chk lerc_chk_i (.*);

/* verif/lerc_tx.sv */
// alignment sequence source in place of the link transmitter
`timescale 1ns/1ps
module lerc_tx (
	// control
	input wire        clk,
	input wire        go,
	input wire [7:0]  bad,
	// lanes
	output reg        ilas_start = 1'b0,
	output reg        ilas_end = 1'b0,
	output reg [7:0]  ilas_valid = 8'h00,
	output reg [63:0] ilas_data = 64'h0
);
	reg [2:0] n = 3'h0;
	integer   x;
	always @(negedge clk) begin
		ilas_start <= go;
		ilas_valid <= {8{n != 3'h0}};
		ilas_end <= n == 3'h4;
		n <= go ? 3'h1 : (n == 3'h4 || n == 3'h0) ? 3'h0 : n + 3'h1;
		for (x = 0; x < 8; x = x + 1)
			ilas_data[8*x+:8] <= n ? {5'h0, n - 3'h1} ^ {8{bad[x] && n == 3'h3}} : 8'hfc;
	end
endmodule

/* verif/tb_top.sv */
// self-checking bench for the lane and test register bank
`timescale 1ns/1ps
module tb_top;
	reg         clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, go = 1'b0;
	reg  [12:0] reg_addr = 13'h0;
	reg  [7:0]  reg_wdata = 8'h00, bad = 8'h00, d, r, e;
	reg  [15:0] a, i_link_data = 16'h0abc, q_link_data = 16'h0def;
	reg  [39:0] rows [0:7];
	wire [7:0]  reg_rdata, link_lane_mask_bits, lane_fail, ilas_valid;
	wire        ilas_start, ilas_end, ilas_failed, startup_ok;
	wire [63:0] ilas_data;
	wire [15:0] i_dac_data, q_dac_data;
	integer     bad_count = 0, check_count = 0, k;
	always #10 clk = ~clk;
	lerc_top lerc_top_i (.*);
	lerc_tx lerc_tx_i (.*);
	task chk(input [31:0] g, input [31:0] x);
		check_count = check_count + 1;
		if (g !== x) begin
			bad_count = bad_count + 1;
			$display("CHECK FAILED %0t got %h want %h", $time, g, x);
		end
	endtask
	task acc(input [1:0] op, input [12:0] ad, input [7:0] wd);
		{reg_rd, reg_wr, reg_addr, reg_wdata} <= {op, ad, wd};
		@(negedge clk);
	endtask
	task nx;
		acc(2'h0, 13'h0, 8'h00);
	endtask
	task results;
		$display("mismatches %0d checks %0d", bad_count, check_count);
		if (bad_count == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task frame(input [7:0] b);
		go <= 1'b1;
		bad <= b;
		nx;
		go <= 1'b0;
		for (k = 0; k < 20 && ilas_end !== 1'b1; k = k + 1) nx;
		if (k == 20) begin
			bad_count = bad_count + 1;
			results;
		end
		nx;
		nx;
	endtask
	initial begin
		rows[0] = 40'h047da500a5;
		rows[1] = 40'h047e010000;
		rows[2] = 40'h05201c1c1c;
		rows[3] = 40'h0521340034;
		rows[4] = 40'h0522120012;
		rows[5] = 40'h0523780078;
		rows[6] = 40'h0524560056;
		rows[7] = 40'h047f990000;
		nx;
		nx;
		resetn <= 1'b1;
		for (k = 0; k < 8; k = k + 1) begin
			{a, d, r, e} = rows[k];
			acc(2'h2, a[12:0], 8'h00);
			chk(reg_rdata, r);
			acc(2'h1, a[12:0], d);
			acc(2'h2, a[12:0], 8'h00);
			chk(reg_rdata, e);
		end
		frame(8'h00);
		chk({lane_fail, ilas_failed, startup_ok}, 10'h001);
		frame(8'h22);
		chk({lane_fail, ilas_failed, startup_ok}, 10'h082);
		acc(2'h1, 13'h047e, 8'h00);
		frame(8'hff);
		chk({lane_fail, ilas_failed, startup_ok}, 10'h001);
		acc(2'h1, 13'h0520, 8'h1e);
		nx;
		nx;
		chk({i_dac_data, q_dac_data}, 32'h12345678);
		acc(2'h1, 13'h0520, 8'h1c);
		{i_link_data, q_link_data} <= 32'h24681357;
		nx;
		nx;
		chk({i_dac_data, q_dac_data}, 32'h24681357);
		resetn <= 1'b0;
		nx;
		resetn <= 1'b1;
		chk({link_lane_mask_bits, reg_rdata, lane_fail, ilas_failed, startup_ok}, 26'h0000000);
		results;
	end
endmodule
